// ### pkg/dipd_pkg.sv
// Package for the digital input pulse detector: register map, field
// positions, reset values, timing constants and the per-input config type.
// Assumes a 50 MHz system clock and a 32-bit APB register bus.
package dipd_pkg;

  // ****************************************
  // Register map (byte addresses)
  // ****************************************
  localparam int          ADDR_W         = 8;
  localparam logic [7:0]  CTRL_OFS       = 8'h00;
  localparam logic [7:0]  DEBOUNCE_OFS   = 8'h04;
  localparam logic [7:0]  LEVEL_OFS      = 8'h08;
  localparam logic [7:0]  COUNT_BASE_OFS = 8'h10;
  localparam int          WORD_BYTES     = 4;

  // ****************************************
  // Field positions and reset values
  // ****************************************
  localparam int          FIELD_W        = 8;
  localparam int          MODE_LSB       = 0;
  localparam int          POL_LSB        = 8;
  localparam int          ROUTE_LSB      = 16;
  localparam logic [31:0] CTRL_RST       = 32'h0000_0000;
  localparam int          DB_W           = 7;
  localparam logic [6:0]  DB_RST_MS      = 7'h0a;
  localparam logic [6:0]  DB_MIN_MS      = 7'h01;
  localparam logic [6:0]  DB_MAX_MS      = 7'h64;
  localparam int          COUNT_W        = 16;

  // ****************************************
  // Timing
  // ****************************************
  localparam int          CLK_PERIOD_NS  = 20;
  localparam int          MS_TICK_NS     = 1000000;
  localparam int          MS_TICK_CYCLES = MS_TICK_NS / CLK_PERIOD_NS;
  localparam int          MAX_INPUTS     = 8;

  // ****************************************
  // Per-input configuration
  // ****************************************
  typedef struct packed {
    logic transition_pulse_mode;
    logic inverting;
    logic to_counter;
  } dipd_cfg_t;

endpackage

// ### verilog/dipd_top.sv
// Digital input pulse detector: per-input synchroniser, shared debounce,
// edge-to-event logic, event routing and counters, APB register slave.
// Assumes contact closed drives the input pin high, and an APB master.
// Functional notes
// RQ1: Pulse mode gives one event per input pulse, on one edge only.
// RQ2: In transition pulse mode every debounced transition gives its own event.
// RQ3: Normal polarity in pulse mode counts the open-to-closed change.
// RQ4: Inverting polarity in pulse mode counts the closed-to-open change.
// RQ5: Transition pulse mode ignores the polarity setting.
// RQ6: A new level needs the debounce time, 1-100 ms and 10 ms at reset.
// RQ7: One debounce time serves all inputs, so writing it changes it for all.
// RQ8: Two standard plus four optional inputs share identical conditioning.
// RQ9: Each input's events go either to setpoints or to pulse counters.
// RQ10: Software should avoid very short debounce times; bounce adds events.
// RQ11: Synchronised inputs; a 1 ms tick times a debounce restarted on change.
//
// Design decisions made here: the register offsets and the APB interface to the registers.
module dipd_top #(
  parameter int NUM_INPUTS  = 6,
  parameter int TICK_CYCLES = dipd_pkg::MS_TICK_CYCLES
) (
  input  wire logic                   core_clk_in,
  input  wire logic                   rst_b_in,
  input  wire logic [NUM_INPUTS-1:0]  contact_in,
  input  wire logic                   psel_in,
  input  wire logic                   penable_in,
  input  wire logic                   pwrite_in,
  input  wire logic [7:0]             paddr_in,
  input  wire logic [31:0]            pwdata_in,
  output logic      [31:0]            prdata_out,
  output logic                        pready_out,
  output logic                        pslverr_out,
  output logic      [NUM_INPUTS-1:0]  level_out,
  output logic      [NUM_INPUTS-1:0]  setpoint_event_out,
  output logic      [NUM_INPUTS-1:0]  counter_event_out
);

  localparam int TICK_W = $clog2(TICK_CYCLES + 1);
  localparam int CW     = dipd_pkg::COUNT_W;

  // ****************************************
  // Parameter checks
  // ****************************************
  if (NUM_INPUTS < 2 || NUM_INPUTS > dipd_pkg::MAX_INPUTS) begin : g_bad_n
    $error("dipd_top: NUM_INPUTS must be 2 to 8");
  end
  if (TICK_CYCLES < 1) begin : g_bad_tick
    $error("dipd_top: TICK_CYCLES must be at least 1");
  end

  // ****************************************
  // Functions
  // ****************************************
  function automatic logic event_hit(input dipd_pkg::dipd_cfg_t c,
                                     input logic new_lvl);
    if (c.transition_pulse_mode) begin
      event_hit = 1'b1;
    end else begin
      event_hit = c.inverting ? !new_lvl : new_lvl;
    end
  endfunction

  function automatic logic db_legal(input logic [31:0] d);
    db_legal = (d <= 32'(dipd_pkg::DB_MAX_MS)) &&
               (d >= 32'(dipd_pkg::DB_MIN_MS));
  endfunction

  // ****************************************
  // Registers and per-input state
  // ****************************************
  logic [31:0]              ctrl_reg;
  logic [dipd_pkg::DB_W-1:0] db_reg;
  logic [TICK_W-1:0]        tick_cnt_reg;
  logic                     tick;
  logic [NUM_INPUTS-1:0]    s1_reg, s2_reg, s3_reg;
  logic [NUM_INPUTS-1:0]    syncd_reg, syncd_q_reg, lvl_reg;
  logic [dipd_pkg::DB_W-1:0] dbc_reg [NUM_INPUTS];
  logic [CW-1:0]            count_reg [NUM_INPUTS];
  logic [NUM_INPUTS-1:0]    sp_ev_reg, ct_ev_reg;
  dipd_pkg::dipd_cfg_t      cfg [NUM_INPUTS];
  logic [31:0]              prdata_reg;

  always_comb begin
    for (int i = 0; i < NUM_INPUTS; i++) begin
      cfg[i].transition_pulse_mode = ctrl_reg[dipd_pkg::MODE_LSB + i];
      cfg[i].inverting             = ctrl_reg[dipd_pkg::POL_LSB + i];
      cfg[i].to_counter            = ctrl_reg[dipd_pkg::ROUTE_LSB + i];
    end
  end

  // ****************************************
  // APB decode
  // ****************************************
  logic       setup, access, wr_en;
  logic       hit_ctrl, hit_db, hit_lvl, hit_cnt;
  logic [7:0] cnt_ofs;
  logic [2:0] cnt_idx;

  assign setup    = psel_in && !penable_in;
  assign access   = psel_in && penable_in;
  assign cnt_ofs  = paddr_in - dipd_pkg::COUNT_BASE_OFS;
  assign cnt_idx  = cnt_ofs[4:2];
  assign hit_ctrl = paddr_in == dipd_pkg::CTRL_OFS;
  assign hit_db   = paddr_in == dipd_pkg::DEBOUNCE_OFS;
  assign hit_lvl  = paddr_in == dipd_pkg::LEVEL_OFS;
  assign hit_cnt  = (paddr_in >= dipd_pkg::COUNT_BASE_OFS) &&
                    (cnt_ofs[1:0] == 2'h0) &&
                    (32'(cnt_ofs[7:2]) < NUM_INPUTS);
  // Zero wait states; an illegal debounce value is refused with an error
  assign pready_out  = 1'b1;
  assign pslverr_out = access &&
                       ((!hit_ctrl && !hit_db && !hit_lvl && !hit_cnt) ||
                        (pwrite_in && hit_db && !db_legal(pwdata_in)));
  assign wr_en       = access && pwrite_in && !pslverr_out;
  assign prdata_out  = prdata_reg;

  // Read data captured in setup so it comes from a flip-flop in access
  always_ff @(posedge core_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      prdata_reg <= 32'h0000_0000;
    end else if (setup && !pwrite_in) begin
      prdata_reg <= 32'h0000_0000;
      if (hit_ctrl) begin
        prdata_reg <= ctrl_reg;
      end else if (hit_db) begin
        prdata_reg <= 32'(db_reg);
      end else if (hit_lvl) begin
        prdata_reg <= 32'(lvl_reg);
      end else if (hit_cnt) begin
        prdata_reg <= 32'(count_reg[cnt_idx]);
      end
    end
  end

  always_ff @(posedge core_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      ctrl_reg <= dipd_pkg::CTRL_RST;
    end else if (wr_en && hit_ctrl) begin
      ctrl_reg <= pwdata_in;
    end
  end

  // Single shared value, so no input can drift from the others
  always_ff @(posedge core_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      db_reg <= dipd_pkg::DB_RST_MS;
    end else if (wr_en && hit_db) begin
      db_reg <= pwdata_in[dipd_pkg::DB_W-1:0]; // RQ7
    end
  end

  // ****************************************
  // Millisecond tick
  // ****************************************
  assign tick = tick_cnt_reg == TICK_W'(TICK_CYCLES - 1);

  always_ff @(posedge core_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      tick_cnt_reg <= '0;
    end else if (tick) begin
      tick_cnt_reg <= '0;
    end else begin
      tick_cnt_reg <= tick_cnt_reg + TICK_W'(1);
    end
  end

  // ****************************************
  // Synchroniser: level taken once stages two and three agree
  // ****************************************
  always_ff @(posedge core_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      s1_reg      <= '0;
      s2_reg      <= '0;
      s3_reg      <= '0;
      syncd_reg   <= '0;
      syncd_q_reg <= '0;
    end else begin
      s1_reg      <= contact_in; // RQ11
      s2_reg      <= s1_reg;
      s3_reg      <= s2_reg;
      syncd_q_reg <= syncd_reg;
      for (int i = 0; i < NUM_INPUTS; i++) begin
        if (s2_reg[i] == s3_reg[i]) begin
          syncd_reg[i] <= s3_reg[i];
        end
      end
    end
  end

  // ****************************************
  // Debounce and event generation, same logic for every input
  // ****************************************
  // Tick phase is free running, so the hold time is between db-1 and db ms
  always_ff @(posedge core_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      lvl_reg   <= '0;
      sp_ev_reg <= '0;
      ct_ev_reg <= '0;
      for (int i = 0; i < NUM_INPUTS; i++) begin
        dbc_reg[i] <= '0;
      end
    end else begin
      sp_ev_reg <= '0;
      ct_ev_reg <= '0;
      for (int i = 0; i < NUM_INPUTS; i++) begin // RQ8
        if (syncd_reg[i] != syncd_q_reg[i] || syncd_reg[i] == lvl_reg[i]) begin
          dbc_reg[i] <= '0; // RQ11
        end else if (tick) begin
          if (dbc_reg[i] + 7'h01 >= db_reg) begin
            dbc_reg[i] <= '0;
            lvl_reg[i] <= syncd_reg[i]; // RQ6
            if (event_hit(cfg[i], syncd_reg[i])) begin // RQ1 RQ2 RQ3 RQ4 RQ5
              sp_ev_reg[i] <= !cfg[i].to_counter; // RQ9
              ct_ev_reg[i] <= cfg[i].to_counter;
            end
          end else begin
            dbc_reg[i] <= dbc_reg[i] + 7'h01;
          end
        end
      end
    end
  end

  assign level_out          = lvl_reg;
  assign setpoint_event_out = sp_ev_reg;
  assign counter_event_out  = ct_ev_reg;

  // ****************************************
  // Pulse counters; a pulse in a clearing write's cycle still counts, leaving 1
  // ****************************************
  always_ff @(posedge core_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      for (int i = 0; i < NUM_INPUTS; i++) begin
        count_reg[i] <= '0;
      end
    end else begin
      for (int i = 0; i < NUM_INPUTS; i++) begin
        if (wr_en && hit_cnt && 32'(cnt_idx) == i) begin
          count_reg[i] <= ct_ev_reg[i] ? CW'(1) : '0;
        end else if (ct_ev_reg[i]) begin
          count_reg[i] <= count_reg[i] + CW'(1); // RQ9
        end
      end
    end
  end

  // ****************************************
  // Assertions
  // ****************************************
  property p_db_write;
    @(posedge core_clk_in) disable iff (!rst_b_in)
      (wr_en && hit_db) |=> db_reg == $past(pwdata_in[dipd_pkg::DB_W-1:0]);
  endproperty
  a_db_write: assert property (p_db_write) // RQ7
    else $error("debounce value not taken on write");

  property p_db_range;
    @(posedge core_clk_in) disable iff (!rst_b_in)
      (db_reg >= dipd_pkg::DB_MIN_MS) && (db_reg <= dipd_pkg::DB_MAX_MS);
  endproperty
  a_db_range: assert property (p_db_range) // RQ6
    else $error("debounce value out of range");

  for (genvar g = 0; g < NUM_INPUTS; g++) begin : g_chk
    property p_accept_after_hold;
      @(posedge core_clk_in) disable iff (!rst_b_in)
        $changed(lvl_reg[g]) |->
          $past(tick) && ($past(dbc_reg[g]) + 7'h01 >= $past(db_reg));
    endproperty
    a_accept_after_hold: assert property (p_accept_after_hold) // RQ6
      else $error("level accepted before debounce time");

    property p_restart;
      @(posedge core_clk_in) disable iff (!rst_b_in)
        (syncd_reg[g] != syncd_q_reg[g]) |=> dbc_reg[g] == 7'h00;
    endproperty
    a_restart: assert property (p_restart) // RQ11
      else $error("debounce count not restarted on change");

    property p_normal_rise;
      @(posedge core_clk_in) disable iff (!rst_b_in)
        ((sp_ev_reg[g] || ct_ev_reg[g]) &&
         !$past(cfg[g].transition_pulse_mode) &&
         !$past(cfg[g].inverting)) |->
          lvl_reg[g] && !$past(lvl_reg[g]);
    endproperty
    a_normal_rise: assert property (p_normal_rise) // RQ3
      else $error("normal polarity event not on closing edge");

    property p_invert_fall;
      @(posedge core_clk_in) disable iff (!rst_b_in)
        ((sp_ev_reg[g] || ct_ev_reg[g]) &&
         !$past(cfg[g].transition_pulse_mode) &&
         $past(cfg[g].inverting)) |->
          !lvl_reg[g] && $past(lvl_reg[g]);
    endproperty
    a_invert_fall: assert property (p_invert_fall) // RQ4
      else $error("inverting polarity event not on opening edge");

    property p_transition_all;
      @(posedge core_clk_in) disable iff (!rst_b_in)
        ($changed(lvl_reg[g]) && $past(cfg[g].transition_pulse_mode)) |->
          (sp_ev_reg[g] || ct_ev_reg[g]);
    endproperty
    a_transition_all: assert property (p_transition_all) // RQ2
      else $error("transition lost in transition pulse mode");

    property p_one_per_edge;
      @(posedge core_clk_in) disable iff (!rst_b_in)
        (sp_ev_reg[g] || ct_ev_reg[g]) |=> !(sp_ev_reg[g] || ct_ev_reg[g]);
    endproperty
    a_one_per_edge: assert property (p_one_per_edge) // RQ1
      else $error("event longer than one cycle");

    property p_route;
      @(posedge core_clk_in) disable iff (!rst_b_in)
        (sp_ev_reg[g] || ct_ev_reg[g]) |->
          (sp_ev_reg[g] != ct_ev_reg[g]) &&
          (ct_ev_reg[g] == $past(cfg[g].to_counter));
    endproperty
    a_route: assert property (p_route) // RQ9
      else $error("event routed to the wrong consumer");
  end

endmodule // dipd_top

// ### dv/dipd_contact_model.sv
// Behavioural bank of external contacts feeding the pulse detector.
// Assumes the bench commands level and bounce right after rising edges.
module dipd_contact_model (
  input  wire logic       clk_in,
  input  wire logic [5:0] level_in,
  input  wire logic [5:0] bounce_in,
  output logic      [5:0] contact_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [5:0] state_reg = 6'h00;
  logic [1:0] div_reg   = 2'h0;
  // Chatter every fourth cycle: slow enough to pass the synchroniser,
  // so only the debounce can keep it out of the events
  always @(posedge clk_in) begin
    div_reg   <= div_reg + 2'h1;
    state_reg <= (bounce_in & (state_reg ^ {6{div_reg == 2'h3}})) |
                 (~bounce_in & level_in);
  end
  assign contact_out = state_reg;
endmodule // dipd_contact_model

// ### dv/dipd_top_tb.sv
// Self-checking bench of the pulse detector with APB register access.
// Assumes a shortened millisecond tick of TICK cycles.
module dipd_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int TICK = 4;
  logic        core_clk = 1'b0;
  logic        rst_b    = 1'b0;
  logic        psel     = 1'b0;
  logic        penable  = 1'b0;
  logic        pwrite   = 1'b0;
  logic [7:0]  paddr    = 8'h00;
  logic [31:0] pwdata   = 32'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [5:0]  level;
  logic [5:0]  sp_ev;
  logic [5:0]  ct_ev;
  logic [5:0]  contact;
  logic [5:0]  lvl_cmd  = 6'h00;
  logic [5:0]  bnc_cmd  = 6'h00;
  int          n_fail   = 0;
  int          n_compared = 0;
  int          sp_n[6];
  int          ct_n[6];
  logic [31:0] rd;
  logic        er;

  always #10 core_clk = ~core_clk;

  dipd_top #(.NUM_INPUTS(6), .TICK_CYCLES(TICK)) dut_u (
    .core_clk_in(core_clk), .rst_b_in(rst_b), .contact_in(contact),
    .psel_in(psel), .penable_in(penable), .pwrite_in(pwrite),
    .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata),
    .pready_out(pready), .pslverr_out(pslverr), .level_out(level),
    .setpoint_event_out(sp_ev), .counter_event_out(ct_ev));

  dipd_contact_model partner_u (
    .clk_in(core_clk), .level_in(lvl_cmd), .bounce_in(bnc_cmd),
    .contact_out(contact));

  // ****************************************
  // Event monitor
  // ****************************************
  always @(posedge core_clk) begin
    for (int i = 0; i < 6; i++) begin
      if (sp_ev[i] === 1'b1) sp_n[i]++;
      if (ct_ev[i] === 1'b1) ct_n[i]++;
    end
  end

  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic chk(string nm, logic [31:0] exp, logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic clr();
    foreach (sp_n[i]) begin
      sp_n[i] = 0;
      ct_n[i] = 0;
    end
  endtask

  task automatic apb(logic w, logic [7:0] a, logic [31:0] d);
    int k;
    @(posedge core_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge core_clk);
      k++;
    end while (pready !== 1'b1 && k < 100);
    chk("pready", 32'h1, 32'(pready));
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // Drives one level change and times its acceptance
  task automatic wait_lvl(int i, logic v, int db);
    int k;
    k = 0;
    lvl_cmd[i] <= v;
    while (level[i] !== v && k < 3000) begin
      @(posedge core_clk);
      k++;
    end
    chk("level", 32'(v), 32'(level[i]));
    chk("delay", 1, 32'(k >= (db - 1) * TICK && k <= (db + 1) * TICK + 8));
    repeat (2) @(posedge core_clk);
  endtask

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_reset();
    apb(1'b0, dipd_pkg::CTRL_OFS, 32'h0);
    chk("ctrl", 32'h0, rd);
    apb(1'b0, dipd_pkg::DEBOUNCE_OFS, 32'h0);
    chk("debounce", 32'h0000_000a, rd);
    apb(1'b0, 8'h40, 32'h0);
    chk("unmapped err", 32'h1, 32'(er));
    chk("unmapped data", 32'h0, rd);
  endtask

  task automatic t_all_normal();
    clr();
    for (int i = 0; i < 6; i++) begin
      wait_lvl(i, 1'b1, 10);
      chk("close event", 1, sp_n[i]);
      wait_lvl(i, 1'b0, 10);
      chk("one per pulse", 1, sp_n[i]);
      chk("no count", 0, ct_n[i]);
    end
  endtask

  task automatic t_invert();
    clr();
    apb(1'b1, dipd_pkg::CTRL_OFS, 32'h0000_0200);
    wait_lvl(1, 1'b1, 10);
    chk("inv close", 0, sp_n[1]);
    wait_lvl(1, 1'b0, 10);
    chk("inv open", 1, sp_n[1]);
  endtask

  task automatic t_transition();
    clr();
    apb(1'b1, dipd_pkg::CTRL_OFS, 32'h0004_0404);
    wait_lvl(2, 1'b1, 10);
    apb(1'b0, dipd_pkg::LEVEL_OFS, 32'h0);
    chk("level reg", 32'h0000_0004, rd);
    wait_lvl(2, 1'b0, 10);
    chk("both edges", 2, ct_n[2]);
    chk("route", 0, sp_n[2]);
    apb(1'b0, dipd_pkg::COUNT_BASE_OFS + 8'h08, 32'h0);
    chk("count", 32'h2, rd);
    apb(1'b1, dipd_pkg::COUNT_BASE_OFS + 8'h08, 32'h0);
    apb(1'b0, dipd_pkg::COUNT_BASE_OFS + 8'h08, 32'h0);
    chk("count clear", 32'h0, rd);
  endtask

  task automatic t_debounce();
    clr();
    apb(1'b1, dipd_pkg::CTRL_OFS, 32'h0);
    apb(1'b1, dipd_pkg::DEBOUNCE_OFS, 32'h0000_0065);
    chk("over max err", 32'h1, 32'(er));
    apb(1'b1, dipd_pkg::DEBOUNCE_OFS, 32'h0000_0000);
    chk("under min err", 32'h1, 32'(er));
    apb(1'b0, dipd_pkg::DEBOUNCE_OFS, 32'h0);
    chk("refused kept", 32'h0000_000a, rd);
    apb(1'b1, dipd_pkg::DEBOUNCE_OFS, 32'h0000_0003);
    chk("debounce write err", 32'h0, 32'(er));
    wait_lvl(5, 1'b1, 3);
    wait_lvl(0, 1'b1, 3);
    wait_lvl(5, 1'b0, 3);
    wait_lvl(0, 1'b0, 3);
    lvl_cmd[5] <= 1'b1;
    repeat (6) @(posedge core_clk);
    lvl_cmd[5] <= 1'b0;
    repeat (40) @(posedge core_clk);
    chk("short pulse", 0, 32'(level[5]));
    chk("short events", 1, sp_n[5]);
    apb(1'b1, dipd_pkg::DEBOUNCE_OFS, 32'h0000_000a);
  endtask

  // Ten ms interval keeps chatter out of the events
  task automatic t_bounce();
    clr();
    bnc_cmd[4] <= 1'b1;
    repeat (30) @(posedge core_clk);
    bnc_cmd[4] <= 1'b0;
    wait_lvl(4, 1'b1, 10);
    chk("bounce events", 1, sp_n[4]);
  endtask

  task automatic conclude();
    $display("compared %0d failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  initial begin
    clr();
    repeat (3) @(posedge core_clk);
    rst_b <= 1'b1;
    t_reset();
    t_all_normal();
    t_invert();
    t_transition();
    t_debounce();
    t_bounce();
    conclude();
  end

  // Whole run needs about 1000 cycles
  initial begin
    #1000000;
    n_fail++;
    conclude();
  end
endmodule // dipd_top_tb
